// [hw/fifo_ctl_pkg.sv]
`default_nettype none
package fifo_ctl_pkg;

    // register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_CONFIG  = 8'h08;
    localparam logic [7:0] REG_LEVEL   = 8'h0C;
    localparam logic [7:0] REG_OFFSETS = 8'h10;

    // control register fields
    localparam int CTRL_PARTIAL_BIT = 0;
    localparam int CTRL_OUT_OFF_BIT = 1;
    localparam logic CTRL_OUT_OFF_RESET = 1'b0;

    // default flag offsets, restored by full reset and by hresetn, not by partial reset
    localparam logic [15:0] EMPTY_OFFSET_RESET = 16'h007F;
    localparam logic [15:0] FULL_OFFSET_RESET  = 16'h007F;

    // fall-through first-word latency in read-clock edges
    localparam logic [1:0] FALL_THROUGH_EDGES = 2'h3;

    // active data-path widths
    localparam int WIDTH_WIDE   = 36;
    localparam int WIDTH_HALF   = 18;
    localparam int WIDTH_NARROW = 9;

    typedef enum logic [0:0] {
        RT_IDLE  = 1'b0,
        RT_SETUP = 1'b1
    } replay_state_t;

    // every pin that crosses into the hclk domain
    typedef struct packed {
        logic        wclk;
        logic        rclk;
        logic        write_gate_n;
        logic        read_gate_n;
        logic        replay_request_n;
        logic        fall_through_serial_pin;
        logic        serial_enable_n;
        logic        full_clear_in_n;
        logic        partial_clear_in_n;
        logic        write_port_strobe_sel_n;
        logic        read_port_strobe_sel_n;
        logic        replay_latency_sel;
        logic        output_width_sel;
        logic        input_width_sel;
        logic        width_match_sel;
        logic        byte_order_sel_n;
        logic        flag_timing_sel;
        logic        interspersed_parity_sel;
        logic        serial_load_sel;
        logic [35:0] data_in_bus;
    } pins_t;

    // configuration caught during full reset
    typedef struct packed {
        logic fall_through_mode;
        logic write_strobe;
        logic read_strobe;
        logic zero_latency;
        logic output_width_sel;
        logic input_width_sel;
        logic width_match_sel;
        logic byte_order_sel_n;
        logic flag_timing_sel;
        logic interspersed_parity_sel;
        logic serial_load;
    } cfg_t;

endpackage : fifo_ctl_pkg
`default_nettype wire

// [hw/fifo_ctl.sv]
// Notes on behaviour
// - data input active width 36, 18 or 9
// - full reset clears pointers, sets flag levels
// - full reset strap picks standard or fall-through
// - static configuration latched during full reset
// - full reset zeroes output register, asynchronously
// - partial reset clears pointers, keeps mode
// - partial reset keeps offsets, zeroes output
// - strobe write port stores on rising edge
// - strobe write: full flag free-running, standard only
// - strobe read port loads output per edge
// - strobe read: standard only, empty free-running
// - output drive enable acts asynchronously
// - replay request low at read edge starts setup
// - standard replay: empty low, then enabled reads
// - fall-through replay: ready returns with first word
// - latency strap selects zero-latency replay
// - standard mode reads only when requested
// - fall-through first word after three read edges
// - serial offset bits enter via fall-through pin
// - write clock updates write flags, half-full low
// - write gate low stores word unless full
// - read gate low loads output unless empty
`timescale 1ns/1ps
`default_nettype none
module fifo_ctl
    import fifo_ctl_pkg::*;
#(
    parameter int DEPTH = 1024
) (
    // ahb-lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // fifo pins
    input  wire pins_t       pins_in,
    input  wire logic        output_drive_enable_n,
    // fifo outputs
    output logic [35:0]      data_out_bus,
    output logic             data_out_oe,
    output logic             empty_indicator_n,
    output logic             full_indicator_n,
    output logic             almost_empty_flag_n,
    output logic             almost_full_flag_n,
    output logic             half_full_flag_n
);

    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 4 || DEPTH > 32768 || (1 << AW) != DEPTH) begin
            $error("fifo_ctl: DEPTH must be a power of two from 4 to 32768");
        end
    end

    localparam logic [AW:0] DEPTH_W = (AW + 1)'(DEPTH);
    localparam logic [AW:0] HALF_W  = (AW + 1)'(DEPTH / 2);

    typedef struct packed {
        pins_t         sync1;
        pins_t         sync2;
        logic          prev_wclk;
        logic          prev_rclk;
        cfg_t          cfg;
        logic [AW:0]   wptr;
        logic [AW:0]   rptr;
        logic [35:0]   out_reg;
        logic          out_valid;
        logic [1:0]    ft_cnt;
        replay_state_t rt;
        logic          ef_n;
        logic          ff_n;
        logic          pae_n;
        logic          paf_n;
        logic          hf_n;
        logic [31:0]   offsets;
        logic          a_valid;
        logic          a_write;
        logic [7:0]    a_addr;
        logic [31:0]   rdata;
        logic          out_off;
        logic          sw_partial;
    } state_t;

    state_t      s;
    state_t      next_s;
    logic [35:0] mem [DEPTH];
    logic        mem_we;
    logic [AW-1:0] mem_waddr;
    logic [35:0] mem_wdata;

    logic        w_edge;
    logic        r_edge;
    logic        full_rst;
    logic        part_rst;
    logic [AW:0] cnt;
    logic [AW:0] cnt_n;
    logic [35:0] in_mask;
    logic [35:0] out_mask;
    logic [35:0] rd_word;
    logic [35:0] first_word;
    logic [16:0] cnt_ext;

    function automatic logic [35:0] width_mask(input logic bm, input logic sel);
        logic [35:0] m;
        m = {36{1'b1}};
        if (bm) begin
            m = sel ? 36'(9'h1FF) : 36'(18'h3FFFF);
        end
        return m;
    endfunction : width_mask

    function automatic state_t clear_fifo(input state_t st);
        state_t r;
        r = st;
        r.wptr      = '0;
        r.rptr      = '0;
        r.out_reg   = '0;
        r.out_valid = 1'b0;
        r.ft_cnt    = '0;
        r.rt        = RT_IDLE;
        r.ef_n      = st.cfg.fall_through_mode;
        r.ff_n      = ~st.cfg.fall_through_mode;
        r.pae_n     = 1'b0;
        r.paf_n     = 1'b1;
        r.hf_n      = 1'b1;
        return r;
    endfunction : clear_fifo

    // synchronised edges and reset levels
    assign w_edge   = s.sync2.wclk & ~s.prev_wclk;
    assign r_edge   = s.sync2.rclk & ~s.prev_rclk;
    assign full_rst = ~s.sync2.full_clear_in_n;
    assign part_rst = ~s.sync2.partial_clear_in_n | s.sw_partial;
    assign cnt      = s.wptr - s.rptr;
    assign in_mask  = width_mask(s.cfg.width_match_sel, s.cfg.input_width_sel);
    assign out_mask = width_mask(s.cfg.width_match_sel, s.cfg.output_width_sel);
    assign rd_word  = mem[s.rptr[AW-1:0]] & out_mask;
    assign first_word = mem[0] & out_mask;

    always_comb begin
        next_s       = s;
        mem_we       = 1'b0;
        mem_waddr    = s.wptr[AW-1:0];
        mem_wdata    = s.sync2.data_in_bus & in_mask;
        cnt_n        = cnt;
        cnt_ext      = '0;
        next_s.sync1 = pins_in;
        next_s.sync2 = s.sync1;
        next_s.prev_wclk  = s.sync2.wclk;
        next_s.prev_rclk  = s.sync2.rclk;
        next_s.sw_partial = 1'b0;

        if (full_rst) begin
            // straps caught for as long as full reset is held
            next_s.cfg.write_strobe = ~s.sync2.write_port_strobe_sel_n;
            next_s.cfg.read_strobe  = ~s.sync2.read_port_strobe_sel_n;
            // strobe ports force standard mode
            next_s.cfg.fall_through_mode = s.sync2.fall_through_serial_pin
                                         & s.sync2.write_port_strobe_sel_n
                                         & s.sync2.read_port_strobe_sel_n;
            next_s.cfg.zero_latency       = s.sync2.replay_latency_sel;
            next_s.cfg.output_width_sel   = s.sync2.output_width_sel;
            next_s.cfg.input_width_sel    = s.sync2.input_width_sel;
            next_s.cfg.width_match_sel    = s.sync2.width_match_sel;
            next_s.cfg.byte_order_sel_n   = s.sync2.byte_order_sel_n;
            next_s.cfg.flag_timing_sel    = s.sync2.flag_timing_sel;
            next_s.cfg.interspersed_parity_sel = s.sync2.interspersed_parity_sel;
            next_s.cfg.serial_load        = s.sync2.serial_load_sel;
            next_s.offsets = {FULL_OFFSET_RESET, EMPTY_OFFSET_RESET};
            next_s = clear_fifo(next_s);
        end else if (part_rst) begin
            // offsets and configuration survive
            next_s = clear_fifo(next_s);
        end else begin
            // write side; enables assumed tied low in strobe mode
            if (w_edge && !s.sync2.write_gate_n && cnt != DEPTH_W) begin
                mem_we      = 1'b1;
                next_s.wptr = s.wptr + 1'b1;
            end
            if (w_edge && s.cfg.serial_load && !s.sync2.serial_enable_n) begin
                next_s.offsets = {s.offsets[30:0], s.sync2.fall_through_serial_pin};
            end

            // read side
            if (r_edge) begin
                if (!s.sync2.replay_request_n && s.rt == RT_IDLE) begin
                    next_s.rptr      = '0;
                    next_s.rt        = RT_SETUP;
                    next_s.out_valid = 1'b0;
                    next_s.ft_cnt    = '0;
                    if (s.cfg.zero_latency && s.wptr != '0) begin
                        next_s.out_reg   = first_word;
                        next_s.rptr      = (AW + 1)'(1);
                        next_s.out_valid = s.cfg.fall_through_mode;
                        next_s.rt        = s.cfg.fall_through_mode ? RT_IDLE : RT_SETUP;
                    end
                end else if (s.rt == RT_SETUP) begin
                    next_s.rt = RT_IDLE;
                    // fall-through: first word arrives with ready
                    if (s.cfg.fall_through_mode && s.wptr != '0) begin
                        next_s.out_reg   = first_word;
                        next_s.rptr      = (AW + 1)'(1);
                        next_s.out_valid = 1'b1;
                    end
                end else if (!s.cfg.fall_through_mode) begin
                    if (!s.sync2.read_gate_n && cnt != '0) begin
                        next_s.out_reg = rd_word;
                        next_s.rptr    = s.rptr + 1'b1;
                    end
                end else if (s.out_valid) begin
                    if (!s.sync2.read_gate_n) begin
                        if (cnt != '0) begin
                            next_s.out_reg = rd_word;
                            next_s.rptr    = s.rptr + 1'b1;
                        end else begin
                            next_s.out_valid = 1'b0;   // last word stays on outputs
                        end
                    end
                end else if (cnt != '0) begin
                    if (s.ft_cnt == FALL_THROUGH_EDGES - 2'h1) begin
                        next_s.out_reg   = rd_word;
                        next_s.rptr      = s.rptr + 1'b1;
                        next_s.out_valid = 1'b1;
                        next_s.ft_cnt    = '0;
                    end else begin
                        next_s.ft_cnt = s.ft_cnt + 2'h1;
                    end
                end else begin
                    next_s.ft_cnt = '0;
                end
            end

            // flags on the new occupancy
            cnt_n   = next_s.wptr - next_s.rptr;
            cnt_ext = 17'(cnt_n);
            if (w_edge || s.cfg.write_strobe) begin
                next_s.ff_n = s.cfg.fall_through_mode ? (cnt_n == DEPTH_W) : (cnt_n != DEPTH_W);
            end
            if (r_edge || s.cfg.read_strobe) begin
                if (s.cfg.fall_through_mode) begin
                    next_s.ef_n = ~next_s.out_valid;
                end else begin
                    next_s.ef_n = (cnt_n != '0) && next_s.rt != RT_SETUP;
                end
            end
            if (w_edge) begin
                next_s.paf_n = cnt_ext < (17'(DEPTH_W) - {1'b0, s.offsets[31:16]});
                if (cnt_n > HALF_W) begin
                    next_s.hf_n = 1'b0;   // write clock only drives half-full low
                end
            end
            if (r_edge) begin
                next_s.pae_n = cnt_ext > {1'b0, s.offsets[15:0]};
                if (cnt_n <= HALF_W) begin
                    next_s.hf_n = 1'b1;
                end
            end
        end

        // bus data phase
        if (s.a_valid && s.a_write && s.a_addr == REG_CTRL) begin
            next_s.sw_partial = hwdata[CTRL_PARTIAL_BIT];
            next_s.out_off    = hwdata[CTRL_OUT_OFF_BIT];
        end
        // bus address phase; read data captured here
        next_s.a_valid = hsel && hready && htrans[1];
        next_s.a_write = hwrite;
        next_s.a_addr  = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                REG_CTRL:    next_s.rdata = 32'(s.out_off) << CTRL_OUT_OFF_BIT;
                REG_STATUS:  next_s.rdata = {22'h0, s.rt == RT_SETUP, s.out_valid, s.ft_cnt,
                                             s.ef_n, s.ff_n, s.pae_n, s.paf_n, s.hf_n, 1'b0};
                REG_CONFIG:  next_s.rdata = 32'(s.cfg);
                REG_LEVEL:   next_s.rdata = 32'(cnt);
                REG_OFFSETS: next_s.rdata = s.offsets;
                default:     next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{sync1: '1, sync2: '1, prev_wclk: 1'b1, prev_rclk: 1'b1, cfg: '0,
                   wptr: '0, rptr: '0, out_reg: '0, out_valid: 1'b0, ft_cnt: '0,
                   rt: RT_IDLE, ef_n: 1'b0, ff_n: 1'b1, pae_n: 1'b0, paf_n: 1'b1,
                   hf_n: 1'b1, offsets: {FULL_OFFSET_RESET, EMPTY_OFFSET_RESET},
                   a_valid: 1'b0, a_write: 1'b0, a_addr: '0, rdata: '0,
                   out_off: CTRL_OUT_OFF_RESET, sw_partial: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // storage kept out of reset on purpose: large and never read before written
    always_ff @(posedge hclk) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // outputs; reset pins override data and flags asynchronously
    logic raw_full;
    logic raw_any;
    assign raw_full = ~pins_in.full_clear_in_n;
    assign raw_any  = raw_full | ~pins_in.partial_clear_in_n;

    assign data_out_bus        = raw_any ? 36'h0_0000_0000 : s.out_reg;
    assign data_out_oe         = ~output_drive_enable_n & ~s.out_off;
    assign almost_empty_flag_n = raw_any ? 1'b0 : s.pae_n;
    assign almost_full_flag_n  = raw_any ? 1'b1 : s.paf_n;
    assign half_full_flag_n    = raw_any ? 1'b1 : s.hf_n;
    assign empty_indicator_n   = raw_full ? pins_in.fall_through_serial_pin :
                                 raw_any  ? s.cfg.fall_through_mode : s.ef_n;
    assign full_indicator_n    = raw_full ? ~pins_in.fall_through_serial_pin :
                                 raw_any  ? ~s.cfg.fall_through_mode : s.ff_n;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s.rdata;

endmodule : fifo_ctl
`default_nettype wire

// [bench/fifo_ctl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module fifo_ctl_properties
    import fifo_ctl_pkg::*;
(
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus answer
    input wire logic        hreadyout,
    input wire logic        hresp,
    // fifo pins
    input wire pins_t       pins_in,
    input wire logic        output_drive_enable_n,
    // fifo outputs
    input wire logic [35:0] data_out_bus,
    input wire logic        data_out_oe,
    input wire logic        empty_indicator_n,
    input wire logic        full_indicator_n,
    input wire logic        almost_empty_flag_n,
    input wire logic        almost_full_flag_n,
    input wire logic        half_full_flag_n
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic fc_n = pins_in.full_clear_in_n;
    wire logic pc_n = pins_in.partial_clear_in_n;

    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
    chk_full_flags: assert property (!fc_n |-> !almost_empty_flag_n && almost_full_flag_n && half_full_flag_n)
        else $error("flag levels wrong in full clear");
    chk_full_zero: assert property (!fc_n |-> data_out_bus == 36'h0)
        else $error("output not zero in full clear");
    chk_mode_strap: assert property (!fc_n |-> empty_indicator_n == pins_in.fall_through_serial_pin
        && full_indicator_n != pins_in.fall_through_serial_pin)
        else $error("mode flags do not follow strap");
    chk_part_flags: assert property (!pc_n |-> !almost_empty_flag_n && almost_full_flag_n && half_full_flag_n)
        else $error("flag levels wrong in partial clear");
    chk_part_zero: assert property (!pc_n |-> data_out_bus == 36'h0)
        else $error("output not zero in partial clear");
    chk_part_empty: assert property (!pc_n |-> full_indicator_n != empty_indicator_n)
        else $error("partial clear not in empty state");
    chk_drive_off: assert property (output_drive_enable_n |-> !data_out_oe)
        else $error("output driven while disabled");
    chk_release_zero: assert property ($rose(fc_n) |-> (data_out_bus == 36'h0) [*3])
        else $error("output moved right after full clear");
endmodule : fifo_ctl_properties

bind fifo_ctl fifo_ctl_properties chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .pins_in(pins_in), .output_drive_enable_n(output_drive_enable_n),
    .data_out_bus(data_out_bus), .data_out_oe(data_out_oe),
    .empty_indicator_n(empty_indicator_n), .full_indicator_n(full_indicator_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
    .half_full_flag_n(half_full_flag_n)
);
`default_nettype wire

// [bench/fifo_host.sv]
`timescale 1ns/1ps
`default_nettype none
module fifo_host (
    // clock
    input  wire logic   hclk,
    // pins toward the fifo
    output logic        wclk,
    output logic        rclk,
    output logic        write_gate_n,
    output logic        read_gate_n,
    output logic        replay_request_n,
    output logic [35:0] data_in_bus
);
    logic idle_n;
    initial begin
        {wclk, rclk} = 2'h0;
        {write_gate_n, read_gate_n, replay_request_n, idle_n} = 4'hF;
        data_in_bus = 36'h0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge hclk);
    endtask : hold
    // strobe ports keep both gates low for good
    task automatic set_gates(input logic g);
        write_gate_n <= g;
        read_gate_n  <= g;
        idle_n       <= g;
        hold(1);
    endtask : set_gates
    // four cycles a level, above the sampler's minimum of three
    task automatic write_word(input logic [35:0] d, input logic g);
        data_in_bus  <= d;
        write_gate_n <= g;
        hold(4);
        wclk <= 1'h1;
        hold(4);
        wclk         <= 1'h0;
        write_gate_n <= idle_n;
        data_in_bus  <= ~d; // released bus never repeats the word
        hold(1);
    endtask : write_word
    task automatic read_word(input logic g);
        read_gate_n <= g;
        hold(4);
        rclk <= 1'h1;
        hold(4);
        rclk        <= 1'h0;
        read_gate_n <= idle_n;
        hold(1);
    endtask : read_word
    task automatic replay();
        write_gate_n     <= 1'h1;
        read_gate_n      <= 1'h1;
        replay_request_n <= 1'h0;
        hold(4);
        rclk <= 1'h1;
        hold(4);
        rclk             <= 1'h0;
        replay_request_n <= 1'h1;
        hold(1);
    endtask : replay
endmodule : fifo_host
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fifo_ctl_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        fc_n, pc_n, ft_pin, sn, zl, oe_n, dout_oe, ef_n, ff_n;
    logic        pae_n, paf_n, hf_n;
    logic        wclk, rclk, wg_n, rg_n, rt_n;
    logic [6:0]  straps;
    logic [35:0] din, dout;
    logic [35:0] w [4];
    pins_t       pins;
    int          mismatches, samples_checked, cycles;

    // serial offset loading stays off: its shifter is outside this bench
    assign pins = {wclk, rclk, wg_n, rg_n, rt_n, ft_pin, 1'h1, fc_n, pc_n, sn, sn, zl, straps, din};

    fifo_ctl dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pins_in(pins), .output_drive_enable_n(oe_n), .data_out_bus(dout),
        .data_out_oe(dout_oe), .empty_indicator_n(ef_n), .full_indicator_n(ff_n),
        .almost_empty_flag_n(pae_n), .almost_full_flag_n(paf_n), .half_full_flag_n(hf_n)
    );
    fifo_host host (
        .hclk(hclk), .wclk(wclk), .rclk(rclk), .write_gate_n(wg_n),
        .read_gate_n(rg_n), .replay_request_n(rt_n), .data_in_bus(din)
    );

    initial begin
        hclk = 1'h0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask : chk
    // narrowest width is always live, so only those bits are compared
    function automatic logic [35:0] low9(input logic [35:0] v);
        return {27'h0, v[8:0]};
    endfunction : low9
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'h1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    task automatic freset(input logic ft, input logic s, input logic z);
        fc_n   <= 1'h0;
        ft_pin <= ft;
        sn     <= s;
        zl     <= z;
        straps <= 7'($urandom());
        repeat (6) @(posedge hclk);
        chk(ef_n, ft, "empty level at full clear");
        chk(ff_n, !ft, "full level at full clear");
        chk(pae_n, 1'h0, "almost empty at full clear");
        chk(paf_n, 1'h1, "almost full at full clear");
        chk(hf_n, 1'h1, "half full at full clear");
        fc_n <= 1'h1;
        repeat (6) @(posedge hclk);
        ahb(1'h0, REG_CONFIG, 32'h0);
        chk(rd, {ft, !s, !s, z, straps}, "latched config");
    endtask : freset

    initial begin
        {hresetn, fc_n, hsel, hwrite, oe_n, zl} = 6'h0;
        {pc_n, ft_pin, sn} = 3'h6;
        {haddr, hwdata, htrans, straps} = 73'h0;
        hsize = 3'h2;
        {mismatches, samples_checked, cycles} = 96'h0;
        void'($urandom(99));
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        ahb(1'h1, REG_CTRL, 32'h3);
        ahb(1'h0, REG_CTRL, 32'h0);
        chk(rd, 36'h2, "ctrl readback");
        chk(dout_oe, 1'h0, "output off by register");
        ahb(1'h1, REG_CTRL, 32'h0);
        ahb(1'h0, 8'h20, 32'h0);
        chk(rd, 36'h0, "unmapped read");
        chk(dout_oe, 1'h1, "output driven");
        oe_n <= 1'h1;
        @(posedge hclk);
        chk(dout_oe, 1'h0, "output off by pin");
        oe_n <= 1'h0;
        for (int m = 0; m < 2; m++) begin
            freset(1'h0, m == 0, 1'h0);
            host.set_gates(m == 0);
            for (int i = 0; i < 4; i++) begin
                w[i] = 36'({$urandom(), $urandom()});
                host.write_word(w[i], 1'h0);
            end
            repeat (4) @(posedge hclk);
            chk(dout, 36'h0, "word shown unrequested");
            if (m == 1) chk(ef_n, 1'h1, "strobe empty flag stuck");
            if (m == 0) begin
                host.write_word(~w[0], 1'h1);
                ahb(1'h0, REG_LEVEL, 32'h0);
                chk(rd, 36'h4, "gated-off write stored");
            end
            for (int i = 0; i < 4; i++) begin
                host.read_word(1'h0);
                chk(low9(dout), low9(w[i]), "read word");
            end
            host.read_word(1'h0);
            chk(low9(dout), low9(w[3]), "read past empty");
            chk(ef_n, 1'h0, "empty after drain");
            if (m == 0) begin
                host.replay();
                chk(ef_n, 1'h0, "empty during setup");
                host.read_word(1'h1);
                chk(ef_n, 1'h1, "setup not done");
                chk(low9(dout), low9(w[3]), "output moved unrequested");
                host.read_word(1'h0);
                chk(low9(dout), low9(w[0]), "replay first word");
                pc_n <= 1'h0;
                repeat (4) @(posedge hclk);
                chk(ef_n, 1'h0, "partial clear empty");
                chk(pae_n, 1'h0, "almost empty at partial clear");
                chk(hf_n, 1'h1, "half full at partial clear");
                pc_n <= 1'h1;
                repeat (6) @(posedge hclk);
                ahb(1'h0, REG_LEVEL, 32'h0);
                chk(rd, 36'h0, "level after partial clear");
            end
            host.set_gates(1'h1);
        end
        for (int z = 0; z < 2; z++) begin
            freset(1'h1, 1'h1, z[0]);
            w[0] = 36'({$urandom(), $urandom()});
            w[1] = 36'({$urandom(), $urandom()});
            host.write_word(w[0], 1'h0);
            host.read_word(1'h1);
            host.read_word(1'h1);
            chk(ef_n, 1'h1, "ready too early");
            host.read_word(1'h1);
            chk(low9(dout), low9(w[0]), "first word fall through");
            chk(ef_n, 1'h0, "ready with first word");
            host.write_word(w[1], 1'h0);
            host.read_word(1'h1);
            chk(low9(dout), low9(w[0]), "second word without read");
            host.read_word(1'h0);
            chk(low9(dout), low9(w[1]), "second word");
            host.replay();
            if (z == 0) begin
                chk(ef_n, 1'h1, "ready during setup");
                host.read_word(1'h1);
            end
            chk(low9(dout), low9(w[0]), "replay first word");
            chk(ef_n, 1'h0, "ready after replay");
        end
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
